//--- logic/pwrs_status.v
// Functional notes
// [RQ1] Operation condition: bit 10 constant current, 9 relay closed, 8 constant voltage.
// [RQ2] Operation condition follows the programmed mode; one means active.
// [RQ3] Operation enable mask is writable and reads back exactly as written; here bit 15 is not stored and reads back as zero.
// [RQ4] Operation summary is OR of enabled operation event bits.
// [RQ5] Operation event register latches events; a read returns then clears it.
// [RQ6] Event bit sets on condition rising edge and holds until read.
// [RQ7] Status preset forces both condition registers to zero, reporting no event.
// [RQ8] Questionable bits: power loss 11, overload 10, relay 9, temp 3, current 1, voltage 0.
// [RQ9] Questionable event register latches events; a read returns then clears it.
// [RQ10] Questionable condition shows live state; reading it has no side effect.
// [RQ11] Questionable summary is OR of enabled questionable event bits.
// [RQ12] Questionable enable mask reads back the stored value.
// [RQ13] Low channel register: channels 1-14 at bits 1-14, bit 0 upper summary.
// [RQ14] High channel register: channels 15-28 at bits 1-14, bits 0 and 15 unused.
// [RQ15] Channel bit sets only when that channel reports and its enable is one; here channels 15-28 have no enable and always set.
// [RQ16] Reading a channel summary register returns then clears it.
// [RQ17] Writable channel enable mask gates channels into the low channel register.
// [RQ18] Host writes masks as integers, one bit per enabled position.
`include "pwrs_defines.vh"

module pwrs_status #(
  // Channels per summary register. The registers are 16 bits wide with bit 0 and
  // bit 15 reserved, so values above 14 do not fit.
  parameter CHAN_HALF = 14
) (
  // Clock and reset.
  input  wire                 sys_clk,
  input  wire                 sys_rst,
  // Programmed operating mode, from logic on this clock.
  input  wire                 constant_current_flag,
  input  wire                 constant_voltage_flag,
  input  wire                 relay_closed_flag,
  // Questionable conditions, from supply pins.
  input  wire                 power_loss_flag,
  input  wire                 overload_flag,
  input  wire                 relay_fault_flag,
  input  wire                 overtemperature_flag,
  input  wire                 current_fault_flag,
  input  wire                 voltage_fault_flag,
  // Per-channel summary reports, from pins; bit 0 is channel 1.
  input  wire [2*CHAN_HALF-1:0] channel_report,
  // Command port.
  input  wire [3:0]           cmd_sel,
  input  wire                 cmd_write,
  input  wire                 cmd_read,
  input  wire [15:0]          cmd_wdata,
  input  wire                 status_preset,
  // Answers and status byte bits.
  output reg  [15:0]          rd_data,
  output reg                  rd_valid,
  output reg                  oper_summary,
  output reg                  ques_summary
);

  // Synchronised pin levels, taken from the second flip-flop of each synchroniser.
  wire [5:0]             ques_sync;
  wire [2*CHAN_HALF-1:0] chan_sync;
  // Last synchronised channel levels, for edge detection.
  reg  [2*CHAN_HALF-1:0] chan_prev;

  // Register state.
  reg [15:0]                    operation_condition;
  reg [`PWRS_OPER_ENAB_W-1:0]   operation_enable_mask;
  reg [15:0]                    operation_event_latch;
  reg [15:0]                    questionable_condition;
  reg [15:0]                    questionable_enable_mask;
  reg [15:0]                    questionable_event_latch;
  reg [15:0]                    channel_summary_low;
  reg [15:0]                    channel_summary_high;
  reg [CHAN_HALF-1:0]           channel_enable_mask;

  // Previous live levels for edge detection.
  reg [15:0]             oper_prev;
  reg [15:0]             ques_prev;

  // Combinational next values.
  reg [15:0]             oper_live;
  reg [15:0]             ques_live;
  reg [15:0]             oper_rise;
  reg [15:0]             ques_rise;
  reg [15:0]             next_oper_event;
  reg [15:0]             next_ques_event;
  reg [15:0]             next_chan_low;
  reg [15:0]             next_chan_high;
  reg [2*CHAN_HALF-1:0]  chan_rise;
  reg [15:0]             next_rd_data;

  // Questionable condition pins pass two flip-flops; power loss sits in the top bit.
  // Each pin is a slow level, so bitwise synchronising is safe: a skew of one
  // cycle between two pins only delays one event by a cycle, it never loses one.
  pwrs_sync2 #(
    .WIDTH (6)
  ) ques_pin_sync (
    .sys_clk  (sys_clk),
    .sys_rst  (sys_rst),
    .async_in ({power_loss_flag, overload_flag, relay_fault_flag,
                overtemperature_flag, current_fault_flag, voltage_fault_flag}),
    .sync_out (ques_sync)
  );

  // Channel report pins pass two flip-flops as well; bit 0 is channel 1.
  pwrs_sync2 #(
    .WIDTH (2*CHAN_HALF)
  ) chan_pin_sync (
    .sys_clk  (sys_clk),
    .sys_rst  (sys_rst),
    .async_in (channel_report),
    .sync_out (chan_sync)
  );

  // Place live levels into their register bit positions.
  // The operation flags come from logic on this clock and need no synchroniser;
  // the questionable levels are read only after their two flip-flops.
  always @* begin
    oper_live = `PWRS_RST_WORD;
    ques_live = `PWRS_RST_WORD;
    // [RQ1] mode bit map
    // [RQ2] programmed mode levels
    oper_live[`PWRS_OPER_CC_BIT]    = constant_current_flag;
    oper_live[`PWRS_OPER_RELAY_BIT] = relay_closed_flag;
    oper_live[`PWRS_OPER_CV_BIT]    = constant_voltage_flag;
    // [RQ8] questionable bit map
    ques_live[`PWRS_QUES_PL_BIT] = ques_sync[5];
    ques_live[`PWRS_QUES_OL_BIT] = ques_sync[4];
    ques_live[`PWRS_QUES_RE_BIT] = ques_sync[3];
    ques_live[`PWRS_QUES_OT_BIT] = ques_sync[2];
    ques_live[`PWRS_QUES_CE_BIT] = ques_sync[1];
    ques_live[`PWRS_QUES_VE_BIT] = ques_sync[0];
  end

  // Edge detection: an event is a live level going from inactive to active.
  // A status preset masks the operation and questionable rising edges of its own cycle, so nothing is
  // reported while the condition registers are being forced to zero.
  always @* begin
    // [RQ6] rising edge detect
    oper_rise = oper_live & ~oper_prev;
    ques_rise = ques_live & ~ques_prev;
    chan_rise = chan_sync & ~chan_prev;
    // [RQ7] preset reports nothing
    if (status_preset) begin
      oper_rise = `PWRS_RST_WORD;
      ques_rise = `PWRS_RST_WORD;
    end
  end

  // Operation event latch: a new event wins over a clearing read in the same cycle,
  // so an edge that lands on the read cycle is kept for the next read, not lost.
  always @* begin
    // [RQ5] clear on read
    next_oper_event = operation_event_latch;
    if (cmd_read && cmd_sel == `PWRS_SEL_OPER_EVENT) begin
      next_oper_event = `PWRS_RST_WORD;
    end
    next_oper_event = next_oper_event | oper_rise;
  end

  // Questionable event latch, with the same set-wins rule as the operation group.
  always @* begin
    // [RQ9] clear on read
    next_ques_event = questionable_event_latch;
    if (cmd_read && cmd_sel == `PWRS_SEL_QUES_EVENT) begin
      next_ques_event = `PWRS_RST_WORD;
    end
    next_ques_event = next_ques_event | ques_rise;
  end

  // Upper channel register: channels above the first half always report, since
  // this block keeps no enable mask for them.
  always @* begin
    // [RQ16] clear on read
    next_chan_high = channel_summary_high;
    if (cmd_read && cmd_sel == `PWRS_SEL_CHAN_HIGH) begin
      next_chan_high = `PWRS_RST_WORD;
    end
    // [RQ14] upper channels at bits 1-14
    next_chan_high[CHAN_HALF:1] = next_chan_high[CHAN_HALF:1]
                                  | chan_rise[2*CHAN_HALF-1:CHAN_HALF];
  end

  // Lower channel register: enabled channels plus the upper register summary.
  // Bit 0 sets again after a clearing read while the upper register still holds
  // a channel, so the host keeps seeing that the upper half needs attention.
  always @* begin
    // [RQ16] clear on read
    next_chan_low = channel_summary_low;
    if (cmd_read && cmd_sel == `PWRS_SEL_CHAN_LOW) begin
      next_chan_low = `PWRS_RST_WORD;
    end
    // [RQ15] enabled channels only
    // [RQ17] channel enable gating
    next_chan_low[CHAN_HALF:1] = next_chan_low[CHAN_HALF:1]
                                 | (chan_rise[CHAN_HALF-1:0] & channel_enable_mask);
    // [RQ13] bit 0 is the upper register summary
    next_chan_low[0] = next_chan_low[0] | (|next_chan_high[CHAN_HALF:1]);
  end

  // Query answer multiplexer; unmapped selectors read zero.
  always @* begin
    next_rd_data = `PWRS_RST_WORD;
    case (cmd_sel)
      `PWRS_SEL_OPER_COND:  next_rd_data = operation_condition;
      // [RQ3] mask readback
      `PWRS_SEL_OPER_ENAB:  next_rd_data = {1'b0, operation_enable_mask};
      `PWRS_SEL_OPER_EVENT: next_rd_data = operation_event_latch;
      `PWRS_SEL_QUES_EVENT: next_rd_data = questionable_event_latch;
      // [RQ10] live view, no side effect
      `PWRS_SEL_QUES_COND:  next_rd_data = questionable_condition;
      // [RQ12] mask readback
      `PWRS_SEL_QUES_ENAB:  next_rd_data = questionable_enable_mask;
      `PWRS_SEL_CHAN_LOW:   next_rd_data = channel_summary_low;
      `PWRS_SEL_CHAN_HIGH:  next_rd_data = channel_summary_high;
      `PWRS_SEL_CHAN_ENAB:  next_rd_data = {1'b0, channel_enable_mask, 1'b0};
      default:              next_rd_data = `PWRS_RST_WORD;
    endcase
  end

  // Condition, event and edge history registers.
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      operation_condition      <= `PWRS_RST_WORD;
      questionable_condition   <= `PWRS_RST_WORD;
      oper_prev                <= `PWRS_RST_WORD;
      ques_prev                <= `PWRS_RST_WORD;
      chan_prev                <= {2*CHAN_HALF{1'b0}};
      operation_event_latch    <= `PWRS_RST_WORD;
      questionable_event_latch <= `PWRS_RST_WORD;
      channel_summary_low      <= `PWRS_RST_WORD;
      channel_summary_high     <= `PWRS_RST_WORD;
    end else begin
      // [RQ7] preset zeroes conditions
      if (status_preset) begin
        operation_condition    <= `PWRS_RST_WORD;
        questionable_condition <= `PWRS_RST_WORD;
      end else begin
        operation_condition    <= oper_live;
        questionable_condition <= ques_live;
      end
      // History tracks live levels so a preset does not create a later edge.
      // The condition registers follow the live levels again one cycle after a
      // preset, and a condition still active then is not reported a second time.
      oper_prev                <= oper_live;
      ques_prev                <= ques_live;
      chan_prev                <= chan_sync;
      operation_event_latch    <= next_oper_event;
      questionable_event_latch <= next_ques_event;
      channel_summary_low      <= next_chan_low;
      channel_summary_high     <= next_chan_high;
    end
  end

  // Operation enable mask. Only the fifteen low bits are stored, so bit 15 of a
  // write is dropped and reads back as zero.
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      operation_enable_mask <= `PWRS_RST_OPER_ENAB;
    end else begin
      // [RQ3] store operation mask
      if (cmd_write && cmd_sel == `PWRS_SEL_OPER_ENAB) begin
        operation_enable_mask <= cmd_wdata[`PWRS_OPER_ENAB_W-1:0];
      end
    end
  end

  // Questionable enable mask, stored as a whole word.
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      questionable_enable_mask <= `PWRS_RST_WORD;
    end else begin
      // [RQ12] store questionable mask
      if (cmd_write && cmd_sel == `PWRS_SEL_QUES_ENAB) begin
        questionable_enable_mask <= cmd_wdata;
      end
    end
  end

  // Channel enable mask. It sits at bits 14 to 1 of the word, matching the
  // channel positions of the lower channel register; bits 0 and 15 are ignored.
  // Writes to any selector that is not a mask change nothing.
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      channel_enable_mask <= `PWRS_RST_CHAN_ENAB;
    end else begin
      // [RQ17] store channel mask
      if (cmd_write && cmd_sel == `PWRS_SEL_CHAN_ENAB) begin
        channel_enable_mask <= cmd_wdata[CHAN_HALF:1];
      end
    end
  end

  // Query answer. The data is captured only on a read, so it stands until the
  // next query; the strobe rises for the one cycle after the read was taken.
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_data  <= `PWRS_RST_WORD;
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= cmd_read;
      if (cmd_read) begin
        rd_data <= next_rd_data;
      end
    end
  end

  // Status byte summary bits. They are formed from the next latch values, so they
  // move on the same edge as the latches and drop on the edge of a clearing read.
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      oper_summary <= 1'b0;
      ques_summary <= 1'b0;
    end else begin
      // [RQ4] operation summary
      oper_summary <= |(next_oper_event & {1'b0, operation_enable_mask});
      // [RQ11] questionable summary
      ques_summary <= |(next_ques_event & questionable_enable_mask);
    end
  end

endmodule

// Two-stage synchroniser for level inputs from outside the clock domain.
// The first stage may go metastable; only the second stage is ever handed on.
module pwrs_sync2 #(
  parameter WIDTH = 1
) (
  // Clock and reset.
  input  wire             sys_clk,
  input  wire             sys_rst,
  // Asynchronous levels in, synchronised levels out.
  input  wire [WIDTH-1:0] async_in,
  output reg  [WIDTH-1:0] sync_out
);

  // Metastability catch stage.
  reg [WIDTH-1:0] meta_stage;

  // Both stages clear to the idle level so no false edge follows reset.
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta_stage <= {WIDTH{1'b0}};
      sync_out   <= {WIDTH{1'b0}};
    end else begin
      meta_stage <= async_in;
      sync_out   <= meta_stage;
    end
  end

endmodule

//--- shared/pwrs_defines.vh
`ifndef PWRS_DEFINES_VH
`define PWRS_DEFINES_VH

// Register selector codes on the command port.
`define PWRS_SEL_OPER_COND   4'h0
`define PWRS_SEL_OPER_ENAB   4'h1
`define PWRS_SEL_OPER_EVENT  4'h2
`define PWRS_SEL_QUES_EVENT  4'h3
`define PWRS_SEL_QUES_COND   4'h4
`define PWRS_SEL_QUES_ENAB   4'h5
`define PWRS_SEL_CHAN_LOW    4'h6
`define PWRS_SEL_CHAN_HIGH   4'h7
`define PWRS_SEL_CHAN_ENAB   4'h8

// Operation group bit positions.
`define PWRS_OPER_CV_BIT     8
`define PWRS_OPER_RELAY_BIT  9
`define PWRS_OPER_CC_BIT     10

// Questionable group bit positions.
`define PWRS_QUES_VE_BIT     0
`define PWRS_QUES_CE_BIT     1
`define PWRS_QUES_OT_BIT     3
`define PWRS_QUES_RE_BIT     9
`define PWRS_QUES_OL_BIT     10
`define PWRS_QUES_PL_BIT     11

// Operation enable mask width (largest value 32767).
`define PWRS_OPER_ENAB_W     15

// Reset values.
`define PWRS_RST_WORD        16'h0000
`define PWRS_RST_OPER_ENAB   15'h0000
`define PWRS_RST_CHAN_ENAB   14'h0000

`endif

//--- verif/pwrs_host.sv
module pwrs_host (
  // Clock.
  input  wire         sys_clk,
  // Command port toward the status block.
  output logic [3:0]  cmd_sel,
  output logic        cmd_write,
  output logic        cmd_read,
  output logic [15:0] cmd_wdata,
  output logic        status_preset
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle command port from time zero.
  initial {cmd_sel, cmd_write, cmd_read, cmd_wdata, status_preset} = '0;
  // whole mask words.
  // Kind 0 queries, 1 writes, 2 presets; held until the taking edge.
  task automatic op(input logic [3:0] s, input logic [1:0] k, input logic [15:0] d);
    cmd_sel <= s;
    cmd_wdata <= d;
    cmd_read <= (k == 2'h0);
    cmd_write <= (k == 2'h1);
    status_preset <= (k == 2'h2);
    @(posedge sys_clk);
  endtask
  // One cycle with no command.
  task automatic idle;
    {cmd_read, cmd_write, status_preset} <= 3'h0;
    @(posedge sys_clk);
  endtask
endmodule

//--- verif/pwrs_status_properties.sv
`include "pwrs_defines.vh"
module pwrs_status_chk (
  // Clock and reset.
  input wire        sys_clk,
  input wire        sys_rst,
  // Command port.
  input wire [3:0]  cmd_sel,
  input wire        cmd_write,
  input wire        cmd_read,
  input wire [15:0] cmd_wdata,
  input wire        status_preset,
  // Answers and summaries.
  input wire [15:0] rd_data,
  input wire        rd_valid,
  input wire        oper_summary,
  input wire        ques_summary
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);
  // A query of one selector, taken at this edge.
  sequence s_rd(logic [3:0] s);
    cmd_read && cmd_sel == s;
  endsequence
  // A preset followed at once by a condition query.
  sequence s_pre_rd;
    status_preset ##1 (s_rd(`PWRS_SEL_OPER_COND) or s_rd(`PWRS_SEL_QUES_COND));
  endsequence
  // Answer strobe follows each query by one cycle; data holds between.
  a_answer_pulse: assert property (rd_valid == $past(cmd_read))
    else $error("answer strobe mismatch");
  a_data_holds: assert property (!cmd_read |=> $stable(rd_data))
    else $error("answer data moved");
  a_oper_unused: assert property (s_rd(`PWRS_SEL_OPER_COND)
    |=> (rd_data & 16'hF8FF) == 16'h0000)
    else $error("operation condition unused bit set");
  a_ques_unused: assert property (cmd_read && (cmd_sel == 4'h3 || cmd_sel == 4'h4)
    |=> (rd_data & 16'hF1F4) == 16'h0000)
    else $error("questionable unused bit set");
  a_chan_high_unused: assert property (s_rd(`PWRS_SEL_CHAN_HIGH)
    |=> !rd_data[15] && !rd_data[0])
    else $error("upper channel unused bit set");
  a_chan_low_top: assert property (s_rd(`PWRS_SEL_CHAN_LOW) |=> !rd_data[15])
    else $error("lower channel bit 15 set");
  a_preset_clears: assert property (s_pre_rd |=> rd_data == 16'h0000)
    else $error("condition not cleared by preset");
  a_oper_sum_masked: assert property (cmd_write && cmd_sel == 4'h1
    && cmd_wdata == 16'h0000 |-> ##2 !oper_summary)
    else $error("operation summary with empty mask");
  a_ques_sum_masked: assert property (cmd_write && cmd_sel == 4'h5
    && cmd_wdata == 16'h0000 |-> ##2 !ques_summary)
    else $error("questionable summary with empty mask");
endmodule
bind pwrs_status pwrs_status_chk chk (.*);

//--- verif/tb_top.sv
`include "pwrs_defines.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  `define CHK(n, e, s) begin n_tests++; if ((s) !== (e)) begin failures++; \
    $display("BAD %s exp %h got %h", n, e, s); end end
  logic        sys_clk = 0;
  logic        sys_rst = 1;
  logic [2:0]  opf = 0;
  logic [5:0]  qf = 0;
  logic [27:0] channel_report = 0;
  wire  [3:0]  cmd_sel;
  wire         cmd_write, cmd_read, status_preset, rd_valid, oper_summary, ques_summary;
  wire  [15:0] cmd_wdata, rd_data;
  logic [15:0] expq[$];
  logic [15:0] e, v, m;
  int          failures = 0;
  int          n_tests = 0;
  logic [3:0]  sels[3] = '{`PWRS_SEL_OPER_ENAB, `PWRS_SEL_QUES_ENAB, `PWRS_SEL_CHAN_ENAB};
  logic [15:0] msk[3] = '{16'h7FFF, 16'hFFFF, 16'h7FFE};
  pwrs_status #(.CHAN_HALF(14)) uut (.*, .constant_current_flag(opf[2]),
    .relay_closed_flag(opf[1]), .constant_voltage_flag(opf[0]), .power_loss_flag(qf[5]),
    .overload_flag(qf[4]), .relay_fault_flag(qf[3]), .overtemperature_flag(qf[2]),
    .current_fault_flag(qf[1]), .voltage_fault_flag(qf[0]));
  pwrs_host host (.*);
  always #20 sys_clk = ~sys_clk;
  // Queries note their answer; writes and gaps note nothing.
  task automatic rd(input logic [3:0] s, input logic [15:0] x);
    expq.push_back(x);
    host.op(s, 2'h0, 16'h0);
  endtask
  task automatic wr(input logic [3:0] s, input logic [15:0] d);
    host.op(s, 2'h1, d);
  endtask
  task automatic gap(input int n);
    repeat (n) host.idle();
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Each answer strobe takes the oldest noted value.
  always @(posedge sys_clk) if (rd_valid === 1'b1) begin
    e = expq.size() ? expq.pop_front() : 16'hXXXX;
    `CHK("rd_data", e, rd_data)
  end
  initial begin
    v = 16'($urandom(32'h9203));
    repeat (2) @(posedge sys_clk);
    sys_rst <= 0;
    @(posedge sys_clk);
    foreach (sels[i]) begin
      v = 16'($urandom);
      rd(sels[i], 16'h0000);
      wr(sels[i], v);
      rd(sels[i], v & msk[i]);
    end
    wr(`PWRS_SEL_OPER_ENAB, 16'h0400);
    wr(`PWRS_SEL_QUES_ENAB, 16'h0E0B);
    wr(`PWRS_SEL_CHAN_ENAB, 16'h0002);
    opf <= 3'h7;
    gap(3);
    `CHK("oper_summary", 1'b1, oper_summary)
    rd(`PWRS_SEL_OPER_COND, 16'h0700);
    opf <= 3'h0;
    gap(3);
    rd(`PWRS_SEL_OPER_EVENT, 16'h0700);
    rd(`PWRS_SEL_OPER_EVENT, 16'h0000);
    gap(3);
    `CHK("oper_summary", 1'b0, oper_summary)
    opf <= 3'h4;
    gap(3);
    host.op(4'h0, 2'h2, 16'h0);
    rd(`PWRS_SEL_OPER_COND, 16'h0000);
    rd(`PWRS_SEL_OPER_COND, 16'h0400);
    rd(`PWRS_SEL_OPER_EVENT, 16'h0400);
    rd(`PWRS_SEL_OPER_EVENT, 16'h0000);
    opf <= 3'h0;
    repeat (3) begin
      v = 16'($urandom);
      qf <= v[5:0];
      m = {4'h0, v[5:3], 5'h0, v[2], 1'b0, v[1:0]};
      gap(6);
      `CHK("ques_summary", |v[5:0], ques_summary)
      rd(`PWRS_SEL_QUES_COND, m);
      rd(`PWRS_SEL_QUES_COND, m);
      rd(`PWRS_SEL_QUES_EVENT, m);
      rd(`PWRS_SEL_QUES_EVENT, 16'h0000);
      qf <= 6'h0;
      gap(6);
    end
    channel_report <= 28'h0004005;
    gap(6);
    rd(`PWRS_SEL_CHAN_HIGH, 16'h0002);
    rd(`PWRS_SEL_CHAN_LOW, 16'h0003);
    rd(`PWRS_SEL_CHAN_LOW, 16'h0000);
    rd(`PWRS_SEL_CHAN_HIGH, 16'h0000);
    rd(4'hF, 16'h0000);
    // empty masks silence latched events; other writes change nothing.
    opf <= 3'h4;
    qf <= 6'h01;
    gap(6);
    `CHK("oper_summary", 1'b1, oper_summary)
    `CHK("ques_summary", 1'b1, ques_summary)
    wr(`PWRS_SEL_OPER_EVENT, 16'hFFFF);
    wr(`PWRS_SEL_OPER_ENAB, 16'h0000);
    wr(`PWRS_SEL_QUES_ENAB, 16'h0000);
    gap(2);
    `CHK("oper_summary", 1'b0, oper_summary)
    `CHK("ques_summary", 1'b0, ques_summary)
    rd(`PWRS_SEL_OPER_EVENT, 16'h0400);
    rd(`PWRS_SEL_QUES_EVENT, 16'h0001);
    gap(1);
    for (int i = 0; i < 10 && expq.size() > 0; i++) @(posedge sys_clk);
    if (expq.size() > 0) failures++;
    summarize();
  end
endmodule
